// File: logic/nvs_pkg.sv
package nvs_pkg;
	// core clock period and width of a stored word
	localparam int CLK_NS = 100;
	localparam int WORD_W = 14;
	// six-bit serial commands, top bit is a don't-care
	localparam logic [5:0] CMD_LOAD_CFG = 6'h00;
	localparam logic [5:0] CMD_LOAD_PROG = 6'h02;
	localparam logic [5:0] CMD_LOAD_DATA = 6'h03;
	localparam logic [5:0] CMD_READ_PROG = 6'h04;
	localparam logic [5:0] CMD_READ_DATA = 6'h05;
	localparam logic [5:0] CMD_INC_ADDR = 6'h06;
	localparam logic [5:0] CMD_RST_ADDR = 6'h16;
	localparam logic [5:0] CMD_BEGIN_INT = 6'h08;
	localparam logic [5:0] CMD_BEGIN_EXT = 6'h18;
	localparam logic [5:0] CMD_END_EXT = 6'h0a;
	localparam logic [5:0] CMD_BULK_PROG = 6'h09;
	localparam logic [5:0] CMD_BULK_DATA = 6'h0b;
	localparam logic [5:0] CMD_ROW_ERASE = 6'h11;
	// address map of the address counter
	localparam logic [15:0] ADDR_RESET = 16'h0000;
	localparam logic [15:0] PROG_TOP = 16'h7fff;
	localparam logic [15:0] CFG_BASE = 16'h8000;
	localparam logic [15:0] UID_TOP = 16'h8003;
	localparam logic [15:0] ID_WORD_ADDR = 16'h8006;
	localparam logic [15:0] CFG1_ADDR = 16'h8007;
	localparam logic [15:0] CFG2_ADDR = 16'h8008;
	localparam logic [15:0] BULK_UID_TOP = 16'h8008;
	// erased values and protect bit positions in configuration word 1
	localparam logic [13:0] WORD_ERASED = 14'h3fff;
	localparam logic [7:0] BYTE_ERASED = 8'hff;
	localparam int CFG1_PROG_PROT_BIT = 7;
	localparam int CFG1_DATA_PROT_BIT = 8;
	// identification word, value is arbitrary
	localparam logic [13:0] DEV_ID_WORD = 14'h2a51;
	// latch, row and memory geometry
	localparam int LATCH_N = 8;
	localparam int LATCH_AW = 3;
	localparam int ROW_N = 32;
	localparam int ROW_AW = 5;
	localparam int DATA_DEPTH = 256;
	localparam int DATA_AW = 8;
	localparam int UID_N = 4;
	localparam int PROG_AW_DEF = 13;
	// timing in microseconds and derived core cycles
	localparam int TMR_W = 20;
	localparam int EXT_WINDOW_US = 2000;
	localparam int POST_END_US = 100;
	localparam int BULK_ERASE_US = 5000;
	localparam int ROW_ERASE_US = 2500;
	localparam int PROG_INT_US = 2500;
	localparam int EXT_WINDOW_CYC = EXT_WINDOW_US * 1000 / CLK_NS;
	localparam int POST_END_CYC = (POST_END_US * 1000 + CLK_NS - 1) / CLK_NS;
	localparam int BULK_ERASE_CYC = (BULK_ERASE_US * 1000 + CLK_NS - 1) / CLK_NS;
	localparam int ROW_ERASE_CYC = (ROW_ERASE_US * 1000 + CLK_NS - 1) / CLK_NS;
	localparam int PROG_INT_CYC = (PROG_INT_US * 1000 + CLK_NS - 1) / CLK_NS;
	// sequencer states and timed operations
	typedef enum logic [1:0] {ST_IDLE, ST_EXT_WIN, ST_TIMED} nvs_state_t;
	typedef enum logic [2:0] {OP_PROG, OP_EXT_END, OP_BULK_PROG, OP_BULK_DATA, OP_ROW,
		OP_ROW_UID} nvs_op_t;
endpackage

// File: logic/nvs_cmd_if.sv
`timescale 1ns/10ps
interface nvs_cmd_if;
	logic cmd_tgl; // flips once per command, link clock
	logic [5:0] code; // held command code
	logic [13:0] data; // held command data
	logic busy; // sequencer busy, core clock
	modport link (output cmd_tgl, output code, output data, input busy);
	modport core (input cmd_tgl, input code, input data, output busy);
endinterface

// File: logic/nvs_link_rx.sv
`timescale 1ns/10ps
module nvs_link_rx import nvs_pkg::*; (
	input wire logic i_lclk,
	input wire logic i_rst_n,
	input wire logic i_cmd_valid,
	input wire logic [5:0] i_cmd_code,
	input wire logic [13:0] i_cmd_data,
	output logic o_link_busy,
	nvs_cmd_if.link lnk
);
	logic tgl_reg; // event toggle toward the core
	logic [5:0] code_reg; // held until the next command
	logic [13:0] data_reg;
	logic busy_s1_reg; // first stage, read only by second
	logic busy_s2_reg;

	// capture a command and flip the toggle; code and data stay stable
	// for the core because the next command comes only after the gap
	always_ff @(posedge i_lclk or negedge i_rst_n) begin
		if (!i_rst_n) begin
			tgl_reg <= 1'b0;
			code_reg <= 6'h00;
			data_reg <= 14'h0000;
		end else if (i_cmd_valid) begin
			tgl_reg <= ~tgl_reg;
			code_reg <= i_cmd_code;
			data_reg <= i_cmd_data;
		end
	end

	// busy level back into the link domain
	always_ff @(posedge i_lclk or negedge i_rst_n) begin
		if (!i_rst_n) begin
			busy_s1_reg <= 1'b0;
			busy_s2_reg <= 1'b0;
		end else begin
			busy_s1_reg <= lnk.busy;
			busy_s2_reg <= busy_s1_reg;
		end
	end

	assign lnk.cmd_tgl = tgl_reg;
	assign lnk.code = code_reg;
	assign lnk.data = data_reg;
	assign o_link_busy = busy_s2_reg;
endmodule // nvs_link_rx

// File: logic/nvs_sequencer.sv
// How it works
// R1: programmer ends external write inside window
// R2: programmer waits post-end delay after end
// R3: low-range bulk erase clears program, configuration
// R4: config-range bulk erase also clears user IDs
// R5: bulk erases finish after bulk erase time
// R6: no program bulk erase above 8008h; the code runs it at any address
// R7: data bulk erase skipped while data protected
// R8: row erase clears 32 words by bits 15:5
// R9: protected row erase ignored outside user IDs
// R10: config-range row erase clears only user IDs
// R11: row erase finishes after row erase time
// R12: eight 14-bit latches hold until begin
// R13: low bits pick latch, block is aligned
// R14: more than eight loads overwrite latches
// R15: protected program memory reads zero, unwritable
// R16: protected data memory reads zero, unwritable
// R17: user IDs, configuration always readable, writable; configuration words are not written by an external write
// R18: protect bits cleared only by bulk erase
// R19: data memory is 256 bytes at 00h-ffh
// R20: configuration word 1 sits at 8007h
// R21: programmer checks identification word at 8006h
// R22: programmer checksum masks configuration, skips data
// R23: six-bit codes 09h, 0bh, 11h for erases
// R24: load configuration sets address to 8000h
// R25: all intervals are parameterised cycle counts
`timescale 1ns/10ps
module nvs_sequencer import nvs_pkg::*; #(
	parameter int PROG_AW = PROG_AW_DEF,
	parameter int EXT_WIN_CYC = EXT_WINDOW_CYC,
	parameter int POST_CYC = POST_END_CYC,
	parameter int BULK_CYC = BULK_ERASE_CYC,
	parameter int ROW_CYC = ROW_ERASE_CYC,
	parameter int PINT_CYC = PROG_INT_CYC
) (
	input wire logic i_mclk,
	input wire logic i_rst_n,
	input wire logic i_lclk,
	input wire logic i_cmd_valid,
	input wire logic [5:0] i_cmd_code,
	input wire logic [13:0] i_cmd_data,
	output logic o_link_busy,
	output logic o_busy,
	output logic [13:0] o_rd_data,
	output logic o_rd_valid,
	output logic [15:0] o_addr,
	output logic o_program_protect_n,
	output logic o_data_protect_n
);
	// command decode ignoring the don't-care top bit
	function automatic logic cmd_is(input logic [5:0] c, input logic [5:0] k);
		return c[4:0] == k[4:0]; // R23
	endfunction

	nvs_cmd_if cif(); // link to core carrier

	// link-side capture runs on the programmer's clock
	nvs_link_rx u_link (
		.i_lclk(i_lclk),
		.i_rst_n(i_rst_n),
		.i_cmd_valid(i_cmd_valid),
		.i_cmd_code(i_cmd_code),
		.i_cmd_data(i_cmd_data),
		.o_link_busy(o_link_busy),
		.lnk(cif.link)
	);

	// nonvolatile arrays, no reset: they model flash contents
	logic [13:0] prog_mem [2**PROG_AW];
	logic [7:0] data_mem [DATA_DEPTH]; // R19
	logic [13:0] uid_mem [UID_N];
	logic [13:0] cfg1_reg; // R20
	logic [13:0] cfg2_reg;

	// control state
	logic tgl_s1_reg; // first stage, read only by second
	logic tgl_s2_reg;
	logic tgl_s3_reg; // edge detect stage
	nvs_state_t state_reg;
	nvs_op_t op_reg;
	logic [TMR_W-1:0] tmr_reg; // down counter of the current interval
	logic [15:0] addr_reg; // address_counter
	logic [13:0] latch_reg [LATCH_N]; // R12
	logic [7:0] dbyte_reg; // data memory byte latch
	logic tgt_data_reg; // last load aimed at data memory
	logic [13:0] rd_data_reg;
	logic rd_valid_reg;

	// decoded conditions
	logic cmd_new; // one core cycle per command
	logic take_idle; // command accepted in idle
	logic take_end; // end command inside the window
	logic fin; // timed operation completes this cycle
	logic wr_now; // program the latched block now
	logic pp_n; // program_protect_n
	logic dp_n; // data_protect_n
	logic in_prog; // address in program memory
	logic in_uid_bulk; // address 8000h-8008h
	logic [15:0] addr_inc;
	logic [PROG_AW-1:0] prog_idx;

	// toggle crossing from the link clock
	always_ff @(posedge i_mclk or negedge i_rst_n) begin
		if (!i_rst_n) begin
			tgl_s1_reg <= 1'b0;
			tgl_s2_reg <= 1'b0;
			tgl_s3_reg <= 1'b0;
		end else begin
			tgl_s1_reg <= cif.cmd_tgl;
			tgl_s2_reg <= tgl_s1_reg;
			tgl_s3_reg <= tgl_s2_reg;
		end
	end

	assign cmd_new = tgl_s2_reg ^ tgl_s3_reg;
	// while busy only the end command inside the window is heard
	assign take_idle = cmd_new && (state_reg == ST_IDLE);
	assign take_end = cmd_new && (state_reg == ST_EXT_WIN) && cmd_is(cif.code, CMD_END_EXT); // R1
	assign fin = (state_reg == ST_TIMED) && (tmr_reg == '0);
	assign wr_now = (fin && (op_reg == OP_PROG)) || take_end;
	assign pp_n = cfg1_reg[CFG1_PROG_PROT_BIT];
	assign dp_n = cfg1_reg[CFG1_DATA_PROT_BIT];
	assign in_prog = addr_reg <= PROG_TOP;
	assign in_uid_bulk = (addr_reg >= CFG_BASE) && (addr_reg <= BULK_UID_TOP); // R4 R10
	// 7fffh wraps to 0000h and ffffh to 8000h
	assign addr_inc = {addr_reg[15], addr_reg[14:0] + 15'h0001};
	assign prog_idx = addr_reg[PROG_AW-1:0];
	assign cif.busy = state_reg != ST_IDLE;

	// sequencer: idle, external window, timed interval
	always_ff @(posedge i_mclk or negedge i_rst_n) begin
		if (!i_rst_n) begin
			state_reg <= ST_IDLE;
			op_reg <= OP_PROG;
			tmr_reg <= '0;
		end else begin
			case (state_reg)
				ST_IDLE: begin
					if (take_idle && cmd_is(cif.code, CMD_BEGIN_INT)) begin
						state_reg <= ST_TIMED;
						op_reg <= OP_PROG;
						tmr_reg <= TMR_W'(PINT_CYC - 1); // R25
					end else if (take_idle && cmd_is(cif.code, CMD_BEGIN_EXT)) begin
						state_reg <= ST_EXT_WIN;
						tmr_reg <= TMR_W'(EXT_WIN_CYC - 1); // R25
					end else if (take_idle && (cmd_is(cif.code, CMD_BULK_PROG) ||
						cmd_is(cif.code, CMD_BULK_DATA))) begin
						// both bulk erases share one interval
						state_reg <= ST_TIMED;
						op_reg <= cmd_is(cif.code, CMD_BULK_PROG) ? OP_BULK_PROG : OP_BULK_DATA;
						tmr_reg <= TMR_W'(BULK_CYC - 1); // R5
					end else if (take_idle && cmd_is(cif.code, CMD_ROW_ERASE)) begin
						// protected or unmapped rows are dropped without a busy phase
						if (in_uid_bulk || (in_prog && pp_n)) begin // R9
							state_reg <= ST_TIMED;
							op_reg <= in_uid_bulk ? OP_ROW_UID : OP_ROW; // R10
							tmr_reg <= TMR_W'(ROW_CYC - 1); // R11
						end
					end
				end
				ST_EXT_WIN: begin
					if (take_end) begin
						state_reg <= ST_TIMED;
						op_reg <= OP_EXT_END;
						tmr_reg <= TMR_W'(POST_CYC - 1); // R2
					end else if (tmr_reg == '0) begin
						state_reg <= ST_IDLE; // window lapsed, write abandoned
					end else begin
						tmr_reg <= tmr_reg - 1'b1;
					end
				end
				ST_TIMED: begin
					if (tmr_reg == '0) begin
						state_reg <= ST_IDLE;
					end else begin
						tmr_reg <= tmr_reg - 1'b1;
					end
				end
				default: begin
					state_reg <= ST_IDLE;
				end
			endcase
		end
	end

	// address counter, loads and latches
	always_ff @(posedge i_mclk or negedge i_rst_n) begin
		if (!i_rst_n) begin
			addr_reg <= ADDR_RESET;
			dbyte_reg <= BYTE_ERASED;
			tgt_data_reg <= 1'b0;
			latch_reg <= '{default: WORD_ERASED};
		end else if (take_idle && cmd_is(cif.code, CMD_LOAD_CFG)) begin
			addr_reg <= CFG_BASE; // R24
			latch_reg[CFG_BASE[LATCH_AW-1:0]] <= cif.data;
			tgt_data_reg <= 1'b0;
		end else if (take_idle && cmd_is(cif.code, CMD_LOAD_PROG)) begin
			latch_reg[addr_reg[LATCH_AW-1:0]] <= cif.data; // R13 R14
			tgt_data_reg <= 1'b0;
		end else if (take_idle && cmd_is(cif.code, CMD_LOAD_DATA)) begin
			dbyte_reg <= cif.data[7:0];
			tgt_data_reg <= 1'b1;
		end else if (take_idle && cmd_is(cif.code, CMD_INC_ADDR)) begin
			addr_reg <= addr_inc;
		end else if (take_idle && cmd_is(cif.code, CMD_RST_ADDR)) begin
			addr_reg <= ADDR_RESET;
		end else if (wr_now || (state_reg == ST_EXT_WIN && tmr_reg == '0)) begin
			// latches hold until the next write is done or the external window lapses
			latch_reg <= '{default: WORD_ERASED}; // R12
		end
	end

	// read path; protected regions answer zero
	always_ff @(posedge i_mclk or negedge i_rst_n) begin
		if (!i_rst_n) begin
			rd_data_reg <= 14'h0000;
			rd_valid_reg <= 1'b0;
		end else begin
			rd_valid_reg <= take_idle && (cmd_is(cif.code, CMD_READ_PROG) ||
				cmd_is(cif.code, CMD_READ_DATA));
			if (take_idle && cmd_is(cif.code, CMD_READ_PROG)) begin
				if (in_prog) begin
					rd_data_reg <= pp_n ? prog_mem[prog_idx] : 14'h0000; // R15
				end else if (addr_reg <= UID_TOP) begin
					rd_data_reg <= uid_mem[addr_reg[1:0]]; // R17
				end else if (addr_reg == ID_WORD_ADDR) begin
					rd_data_reg <= DEV_ID_WORD;
				end else if (addr_reg == CFG1_ADDR) begin
					rd_data_reg <= cfg1_reg; // R17
				end else if (addr_reg == CFG2_ADDR) begin
					rd_data_reg <= cfg2_reg;
				end else begin
					rd_data_reg <= 14'h0000;
				end
			end else if (take_idle && cmd_is(cif.code, CMD_READ_DATA)) begin
				rd_data_reg <= dp_n ? {6'h00, data_mem[addr_reg[DATA_AW-1:0]]} : 14'h0000; // R16
			end
		end
	end

	// flash array updates; word programming and external data writes only clear bits, internal data writes replace the byte, erase sets them
	always_ff @(posedge i_mclk) begin
		if (wr_now && tgt_data_reg) begin
			if (dp_n) begin // R16
				// internal writes erase the byte first, external ones do not
				data_mem[addr_reg[DATA_AW-1:0]] <= take_end ?
					(data_mem[addr_reg[DATA_AW-1:0]] & dbyte_reg) : dbyte_reg;
			end
		end else if (wr_now) begin
			for (int i = 0; i < LATCH_N; i++) begin
				automatic logic [15:0] wa = {addr_reg[15:LATCH_AW], LATCH_AW'(i)}; // R13
				if (wa <= PROG_TOP) begin
					if (pp_n) begin // R15
						prog_mem[wa[PROG_AW-1:0]] <= prog_mem[wa[PROG_AW-1:0]] & latch_reg[i];
					end
				end else if (wa <= UID_TOP) begin
					uid_mem[wa[1:0]] <= uid_mem[wa[1:0]] & latch_reg[i]; // R17
				end else if (wa == CFG1_ADDR && !take_end) begin
					cfg1_reg <= cfg1_reg & latch_reg[i]; // R18
				end else if (wa == CFG2_ADDR && !take_end) begin
					cfg2_reg <= cfg2_reg & latch_reg[i];
				end
			end
		end else if (fin && op_reg == OP_BULK_PROG) begin
			prog_mem <= '{default: WORD_ERASED}; // R3
			cfg1_reg <= WORD_ERASED; // R18
			cfg2_reg <= WORD_ERASED;
			if (in_uid_bulk) begin
				uid_mem <= '{default: WORD_ERASED}; // R4
			end
			if (!dp_n) begin
				data_mem <= '{default: BYTE_ERASED}; // R3
			end
		end else if (fin && op_reg == OP_BULK_DATA && dp_n) begin
			data_mem <= '{default: BYTE_ERASED}; // R7
		end else if (fin && op_reg == OP_ROW) begin
			for (int j = 0; j < ROW_N; j++) begin
				automatic logic [15:0] ra = {addr_reg[15:ROW_AW], ROW_AW'(j)}; // R8
				prog_mem[ra[PROG_AW-1:0]] <= WORD_ERASED;
			end
		end else if (fin && op_reg == OP_ROW_UID) begin
			uid_mem <= '{default: WORD_ERASED}; // R10
		end
	end

	assign o_busy = state_reg != ST_IDLE;
	assign o_rd_data = rd_data_reg;
	assign o_rd_valid = rd_valid_reg;
	assign o_addr = addr_reg;
	assign o_program_protect_n = pp_n;
	assign o_data_protect_n = dp_n;

	default clocking dc @(posedge i_mclk); endclocking
	default disable iff (!i_rst_n);

	// checks
	sequence s_bulk_start;
		take_idle && cmd_is(cif.code, CMD_BULK_PROG);
	endsequence
	sequence s_busy8;
		o_busy [*8];
	endsequence

	chk_load_cfg_addr: assert property (take_idle && cmd_is(cif.code, CMD_LOAD_CFG) |=> // R24
		addr_reg == 16'h8000 && latch_reg[0] == $past(cif.data))
		else $error("load configuration did not set address");
	chk_latch_load: assert property (take_idle && cmd_is(cif.code, CMD_LOAD_PROG) |=> // R13
		latch_reg[$past(addr_reg[2:0])] == $past(cif.data))
		else $error("latch not loaded by low address bits");
	chk_bulk_hold: assert property (s_bulk_start |=> s_busy8) // R5
		else $error("bulk erase ended too soon");
	chk_row_ignored: assert property (take_idle && cmd_is(cif.code, CMD_ROW_ERASE) && // R9
		in_prog && !pp_n |=> state_reg == ST_IDLE [*2])
		else $error("protected row erase was not ignored");
	chk_prog_read_zero: assert property (take_idle && cmd_is(cif.code, CMD_READ_PROG) && // R15
		in_prog && !pp_n |=> o_rd_valid && o_rd_data == 14'h0000)
		else $error("protected program read not zero");
	chk_data_read_zero: assert property (take_idle && cmd_is(cif.code, CMD_READ_DATA) && // R16
		!dp_n |=> o_rd_valid && o_rd_data == 14'h0000)
		else $error("protected data read not zero");
	chk_bulk_unprotect: assert property (fin && op_reg == OP_BULK_PROG |=> // R18
		o_program_protect_n && o_data_protect_n)
		else $error("bulk erase left protection set");
	chk_bulkd_protect: assert property (fin && op_reg == OP_BULK_DATA && !dp_n |=> // R7
		data_mem[0] == $past(data_mem[0]))
		else $error("protected data memory was erased");
	chk_row_uid_only: assert property (fin && op_reg == OP_ROW_UID |=> // R10
		uid_mem[0] == 14'h3fff && prog_mem[0] == $past(prog_mem[0]))
		else $error("user id row erase touched program memory");
	chk_row_clear: assert property (fin && op_reg == OP_ROW |=> // R8
		prog_mem[{$past(addr_reg[PROG_AW-1:ROW_AW]), 5'h1f}] == 14'h3fff)
		else $error("row erase left a word set");
endmodule // nvs_sequencer

// File: tb/nvs_prog_model.sv
`timescale 1ns/10ps
module nvs_prog_model import nvs_pkg::*; (
	input wire logic i_link_busy,
	output logic o_lclk,
	output logic o_cmd_valid,
	output logic [5:0] o_cmd_code,
	output logic [13:0] o_cmd_data
);
	logic run = 1'b0; // link clock runs only inside a frame

	// gated link clock, phase offset from the core clock
	initial begin
		o_lclk = 1'b0;
		#3;
		forever #7.5 o_lclk = run ? ~o_lclk : 1'b0;
	end

	// idle lines at time zero
	initial begin
		o_cmd_valid = 1'b0;
		o_cmd_code = 6'h3f;
		o_cmd_data = 14'h0;
	end

	// one command, then the gap the core needs before the next
	task automatic send(input logic [5:0] c, input logic [13:0] d, input bit wt);
		int n;
		run = 1'b1;
		@(posedge o_lclk);
		#1;
		o_cmd_valid = 1'b1;
		o_cmd_code = c;
		o_cmd_data = d;
		@(posedge o_lclk);
		#1;
		o_cmd_valid = 1'b0;
		// released lines never keep the last value
		o_cmd_code = ~c;
		o_cmd_data = ~d;
		// covers the ordinary gap and the busy sync delay
		repeat (50) @(posedge o_lclk);
		n = 0;
		// waits out erase, write or post-end time; bounded
		while (wt && i_link_busy !== 1'b0 && n < 20000) begin
			@(posedge o_lclk);
			n++;
		end
		run = 1'b0;
	endtask
endmodule // nvs_prog_model

// File: tb/nvm_erase_program_protect_tb.sv
`timescale 1ns/10ps
module nvm_erase_program_protect_tb import nvs_pkg::*;;
	localparam int EXT = 40; // short intervals keep the run brief
	localparam int BULK = 20;
	localparam int ROW = 20;
	localparam int PAW = 6; // small program memory keeps the checksum sweep short
	logic mclk; // core clock
	logic rst_n = 1'b0; // reset held from time zero
	logic lclk; // link clock from the programmer
	logic cmd_valid;
	logic [5:0] cmd_code;
	logic [13:0] cmd_data;
	logic link_busy;
	logic busy;
	logic [13:0] rd_data;
	logic rd_valid;
	logic [15:0] addr;
	logic pp_n; // low = program memory protected
	logic dp_n; // low = data memory protected
	logic [13:0] rd_last; // last word read out
	int busy_len = 0; // cycles in current busy run
	int last_len = 0; // length of last finished run
	int busy_runs = 0; // busy runs finished so far
	int runs0; // run count before a command
	logic [15:0] cs; // programmer checksum
	int num_errors = 0;
	int total_checks = 0;
	logic [13:0] w [8]; // expected latch image
	logic [13:0] u; // user id word
	logic [13:0] v; // external write word

	nvs_sequencer #(.PROG_AW(PAW), .EXT_WIN_CYC(EXT), .POST_CYC(10), .BULK_CYC(BULK),
		.ROW_CYC(ROW), .PINT_CYC(20)) DUT (.i_mclk(mclk), .i_rst_n(rst_n), .i_lclk(lclk),
		.i_cmd_valid(cmd_valid), .i_cmd_code(cmd_code), .i_cmd_data(cmd_data),
		.o_link_busy(link_busy), .o_busy(busy), .o_rd_data(rd_data), .o_rd_valid(rd_valid),
		.o_addr(addr), .o_program_protect_n(pp_n), .o_data_protect_n(dp_n));

	nvs_prog_model u_prog (.i_link_busy(link_busy), .o_lclk(lclk), .o_cmd_valid(cmd_valid),
		.o_cmd_code(cmd_code), .o_cmd_data(cmd_data));

	// 10 MHz core clock
	initial begin
		mclk = 1'b0;
		forever #50 mclk = ~mclk;
	end

	// capture read words and measure busy runs
	always @(posedge mclk) begin
		if (rd_valid === 1'b1)
			rd_last <= rd_data;
		if (busy === 1'b1) begin
			busy_len <= busy_len + 1;
		end else if (busy_len != 0) begin
			last_len <= busy_len;
			busy_len <= 0;
			busy_runs <= busy_runs + 1;
		end
	end

	task automatic check(input string what, input logic [15:0] exp, input logic [15:0] got);
		total_checks++;
		if (got !== exp) begin
			num_errors++;
			$display("CHECK FAILED %s expected %h seen %h", what, exp, got);
		end
	endtask

	task automatic cmd(input logic [5:0] c, input logic [13:0] d, input bit wt);
		u_prog.send(c, d, wt);
	endtask

	// read command, masked compare of the returned word
	task automatic rd(input logic [5:0] c, input logic [13:0] exp, input logic [13:0] m);
		cmd(c, 14'h0, 1'b0);
		check("read", {2'b0, exp & m}, {2'b0, rd_last & m});
	endtask

	// the run length lands one core edge after busy falls, the link sees it earlier
	task automatic len(input int n);
		repeat (2) @(posedge mclk);
		check("busy cycles", 16'(n), 16'(last_len));
	endtask

	// checksum a blank part gives: every word erased plus masked config words
	function automatic logic [15:0] blank_sum(input int words);
		return 16'(words * 16'h3fff + 16'h3fff + 16'h3733);
	endfunction

	task automatic inc(input int n);
		repeat (n) cmd(CMD_INC_ADDR, 14'h0, 1'b0);
	endtask

	// no decrement exists, so start from 0000h or 8000h
	task automatic seek(input logic [15:0] a, input logic [13:0] d);
		if (a[15])
			cmd(CMD_LOAD_CFG, d, 1'b0);
		else
			cmd(CMD_RST_ADDR, 14'h0, 1'b0);
		inc(int'(a[14:0]));
		check("addr", a, addr);
	endtask

	task automatic finish_test();
		if (num_errors == 0 && total_checks > 0)
			$display("ALL CHECKS OK");
		else
			$display("CHECKS NOT OK");
		$finish;
	endtask

	// hang guard, far beyond the expected run time
	initial begin
		#5000000;
		num_errors++;
		finish_test();
	end

	initial begin
		void'($urandom(32'h2bf4));
		repeat (5) @(posedge mclk);
		#1;
		rst_n = 1'b1;
		check("addr", ADDR_RESET, addr);
		// blank part: erase with user ids in reach
		seek(CFG_BASE, 14'h3fff);
		cmd(CMD_BULK_PROG, 14'h0, 1'b1);
		len(BULK);
		check("protect", 16'h3, {14'h0, pp_n, dp_n});
		// ten loads from 0002h: latch index wraps, 2 and 3 overwritten
		seek(16'h0002, 14'h0);
		for (int i = 2; i < 12; i++) begin
			w[i % 8] = 14'($urandom);
			cmd(CMD_LOAD_PROG, w[i % 8], 1'b0);
			if (i < 11)
				inc(1);
		end
		cmd(CMD_BEGIN_INT, 14'h0, 1'b1);
		seek(16'h0002, 14'h0);
		rd(CMD_READ_PROG, WORD_ERASED, 14'h3fff);
		inc(6);
		for (int k = 0; k < 8; k++) begin
			rd(CMD_READ_PROG, w[k], 14'h3fff);
			inc(1);
		end
		// word in the next row must survive a row erase
		inc(16);
		u = 14'($urandom);
		cmd(CMD_LOAD_PROG, u, 1'b0);
		cmd(CMD_BEGIN_INT, 14'h0, 1'b1);
		seek(16'h001f, 14'h0);
		cmd(CMD_ROW_ERASE, 14'h0, 1'b1);
		len(ROW);
		seek(16'h0008, 14'h0);
		rd(CMD_READ_PROG, WORD_ERASED, 14'h3fff);
		inc(24);
		rd(CMD_READ_PROG, u, 14'h3fff);
		// data byte written then read back
		v = 14'($urandom) & 14'h3ffe; // low bit clear so an erase shows
		seek(ADDR_RESET, 14'h0);
		cmd(CMD_LOAD_DATA, v, 1'b0);
		cmd(CMD_BEGIN_INT, 14'h0, 1'b1);
		rd(CMD_READ_DATA, v, 14'h00ff);
		// unprotected data erase, then the byte written again for later
		cmd(CMD_BULK_DATA, 14'h0, 1'b1);
		len(BULK);
		rd(CMD_READ_DATA, 14'h00ff, 14'h00ff);
		cmd(CMD_LOAD_DATA, v, 1'b0);
		cmd(CMD_BEGIN_INT, 14'h0, 1'b1);
		// user id in latch 0, both protect bits low in latch 7
		seek(CFG_BASE, u);
		inc(7);
		cmd(CMD_LOAD_PROG, 14'h3e7f, 1'b0);
		cmd(CMD_BEGIN_INT, 14'h0, 1'b1);
		check("protect", 16'h0, {14'h0, pp_n, dp_n});
		rd(CMD_READ_PROG, 14'h3e7f, 14'h3fff);
		seek(CFG_BASE, 14'h3fff);
		rd(CMD_READ_PROG, u, 14'h3fff);
		seek(16'h0008, 14'h0);
		rd(CMD_READ_PROG, 14'h0, 14'h3fff);
		rd(CMD_READ_DATA, 14'h0, 14'h00ff);
		runs0 = busy_runs;
		cmd(CMD_ROW_ERASE, 14'h0, 1'b1);
		repeat (2) @(posedge mclk);
		check("busy runs", 16'(runs0), 16'(busy_runs));
		// row erase in config space hits only user ids
		seek(CFG_BASE, 14'h3fff);
		cmd(CMD_ROW_ERASE, 14'h0, 1'b1);
		rd(CMD_READ_PROG, WORD_ERASED, 14'h3fff);
		inc(7);
		rd(CMD_READ_PROG, 14'h3e7f, 14'h3fff);
		cmd(CMD_BULK_DATA, 14'h0, 1'b1);
		len(BULK);
		check("protect", 16'h0, {14'h0, pp_n, dp_n});
		seek(CFG_BASE, u);
		cmd(CMD_BEGIN_INT, 14'h0, 1'b1);
		// low-range bulk erase keeps user ids, clears data
		seek(ADDR_RESET, 14'h0);
		cmd(CMD_BULK_PROG, 14'h0, 1'b1);
		check("protect", 16'h3, {14'h0, pp_n, dp_n});
		rd(CMD_READ_DATA, 14'h00ff, 14'h00ff);
		rd(CMD_READ_PROG, WORD_ERASED, 14'h3fff);
		seek(CFG_BASE, 14'h3fff);
		rd(CMD_READ_PROG, u, 14'h3fff);
		inc(6);
		rd(CMD_READ_PROG, DEV_ID_WORD, 14'h3fff);
		inc(1);
		rd(CMD_READ_PROG, WORD_ERASED, 14'h3fff);
		// programmer checksum of the blank part, carries past 16 bits dropped
		cs = 16'h0;
		seek(ADDR_RESET, 14'h0);
		for (int a = 0; a < 2**PAW; a++) begin
			cmd(CMD_READ_PROG, 14'h0, 1'b0);
			cs = cs + 16'(rd_last);
			inc(1);
		end
		seek(CFG1_ADDR, 14'h3fff);
		cmd(CMD_READ_PROG, 14'h0, 1'b0);
		cs = cs + 16'(rd_last & 14'h3fff);
		inc(1);
		cmd(CMD_READ_PROG, 14'h0, 1'b0);
		cs = cs + 16'(rd_last & 14'h3733);
		check("checksum", blank_sum(2**PAW), cs);
		// external write ended in time, then one left to lapse
		v = 14'($urandom);
		seek(ADDR_RESET, 14'h0);
		cmd(CMD_LOAD_PROG, v, 1'b0);
		cmd(CMD_BEGIN_EXT, 14'h0, 1'b0);
		cmd(CMD_END_EXT, 14'h0, 1'b1);
		rd(CMD_READ_PROG, v, 14'h3fff);
		inc(1);
		cmd(CMD_LOAD_PROG, ~v, 1'b0);
		cmd(CMD_BEGIN_EXT, 14'h0, 1'b1);
		rd(CMD_READ_PROG, WORD_ERASED, 14'h3fff);
		finish_test();
	end
endmodule // nvm_erase_program_protect_tb
